// File: asram_ctl_defs.vh
// Constants for the asynchronous static memory controller.
// Assumes a 40 MHz system clock; included by asram_ctl.v.
`ifndef ASRAM_CTL_DEFS_VH
`define ASRAM_CTL_DEFS_VH

// ***************************
// Clock and timing
// ***************************
`define ASRAM_CLK_MHZ 40
`define ASRAM_PERIOD_PS 25000
// Power-up wait before first access, in ms
`define ASRAM_POWERUP_MS 1
`define ASRAM_POWERUP_CYC (`ASRAM_POWERUP_MS * `ASRAM_CLK_MHZ * 1000)
// Strobe-low-to-float and data setup times, in ps (slowest grade)
`define ASRAM_FLOAT_PS 6000
`define ASRAM_SETUP_PS 6000
// Write strobe low time in cycles: float plus setup, rounded up
`define ASRAM_WR_CYC ((`ASRAM_FLOAT_PS + `ASRAM_SETUP_PS + `ASRAM_PERIOD_PS - 1) / `ASRAM_PERIOD_PS)
// Access time, in ps, and read wait rounded up
`define ASRAM_ACCESS_PS 12000
`define ASRAM_RD_CYC ((`ASRAM_ACCESS_PS + `ASRAM_PERIOD_PS - 1) / `ASRAM_PERIOD_PS)

// ***************************
// Geometry
// ***************************
`define ASRAM_ADDR_W 21
`define ASRAM_DATA_W 8
// Wait counter width; covers the default power-up count
`define ASRAM_CNT_W 17

`endif

// File: asram_ctl.v
// Host-side controller for a 2M x 8 asynchronous static memory.
// Assumes single clock, synchronous pin inputs, and a memory wired directly to the pins.
//
// What this block does
// - Write: low select low, high select high, strobe low; output enable held high.
// - Read: both selects active, output enable low, strobe high; device drives data.
// - Write window is overlap of both selects and strobe low.
// - Controller times write data against the edge that ends the write.
// - Controller waits at least 1 ms after power-up before first access.
// - Strobe write lasts float time plus setup, rounded up, with output enable held high.
// - Address valid no later than selects become active on reads.
`include "asram_ctl_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module asram_ctl #(
   parameter ADDR_W = `ASRAM_ADDR_W,
   parameter DATA_W = `ASRAM_DATA_W,
   parameter POWERUP_CYC = `ASRAM_POWERUP_CYC,
   parameter WR_CYC = `ASRAM_WR_CYC,
   parameter RD_CYC = `ASRAM_RD_CYC
) (
   // Clock, reset, enable
   input wire sys_clk,
   input wire nrst,
   input wire clk_en,
   // User request
   input wire req_valid,
   input wire req_write,
   input wire [ADDR_W-1:0] req_addr,
   input wire [DATA_W-1:0] req_wdata,
   output reg req_ready,
   output reg rd_valid,
   output reg [DATA_W-1:0] rd_data,
   output reg powered,
   // Memory pins
   output reg [ADDR_W-1:0] word_address,
   output reg select_low_active_n,
   output reg select_high_active,
   output reg out_enable_n,
   output reg write_strobe_n,
   input wire [DATA_W-1:0] data_port_in,
   output reg [DATA_W-1:0] data_port_out,
   output reg data_port_oe
);

   // ***************************
   // States
   // ***************************
   localparam ST_PWR = 3'h0;
   localparam ST_IDLE = 3'h1;
   localparam ST_SETUP = 3'h2;
   localparam ST_WR = 3'h3;
   localparam ST_WEND = 3'h4;
   localparam ST_RD = 3'h5;
   localparam ST_REND = 3'h6;

   // ***************************
   // Counter end points
   // ***************************
   // A power-up count beyond the counter width needs a wider counter
   localparam CNT_W = `ASRAM_CNT_W;
   localparam [31:0] PWR_LAST_FULL = POWERUP_CYC - 1;
   localparam [31:0] WR_LAST_FULL = WR_CYC - 1;
   localparam [31:0] RD_LAST_FULL = RD_CYC - 1;
   localparam [CNT_W-1:0] PWR_LAST = PWR_LAST_FULL[CNT_W-1:0];
   localparam [CNT_W-1:0] WR_LAST = WR_LAST_FULL[CNT_W-1:0];
   localparam [CNT_W-1:0] RD_LAST = RD_LAST_FULL[CNT_W-1:0];

   // ***************************
   // Helpers
   // ***************************
   // Count end test shared by the power-up, strobe and read waits
   function cnt_at;
      input [CNT_W-1:0] value;
      input [CNT_W-1:0] last;
      begin
         cnt_at = (value == last);
      end
   endfunction

   reg [2:0] state;
   reg [2:0] next_state;
   reg [CNT_W-1:0] cnt;
   reg is_write;
   wire pwr_done;
   wire wr_done;
   wire rd_done;

   assign pwr_done = cnt_at(cnt, PWR_LAST);
   assign wr_done = cnt_at(cnt, WR_LAST);
   assign rd_done = cnt_at(cnt, RD_LAST);

   // ***************************
   // Next state
   // ***************************
   always @* begin
      next_state = state;
      case (state)
         ST_PWR: begin
            if (pwr_done) begin
               next_state = ST_IDLE;
            end
         end
         ST_IDLE: begin
            if (req_valid) begin
               next_state = ST_SETUP;
            end
         end
         ST_SETUP: begin
            if (is_write) begin
               next_state = ST_WR;
            end else begin
               next_state = ST_RD;
            end
         end
         ST_WR: begin
            if (wr_done) begin
               next_state = ST_WEND;
            end
         end
         ST_WEND: begin
            next_state = ST_IDLE;
         end
         ST_RD: begin
            if (rd_done) begin
               next_state = ST_REND;
            end
         end
         ST_REND: begin
            next_state = ST_IDLE;
         end
         default: begin
            next_state = ST_PWR;
         end
      endcase
   end

   // ***************************
   // Sequencer
   // ***************************
   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         state <= ST_PWR;
         cnt <= {CNT_W{1'b0}};
         is_write <= 1'b0;
         req_ready <= 1'b0;
         rd_valid <= 1'b0;
         rd_data <= {DATA_W{1'b0}};
         powered <= 1'b0;
         word_address <= {ADDR_W{1'b0}};
         select_low_active_n <= 1'b1;
         select_high_active <= 1'b0;
         out_enable_n <= 1'b1;
         write_strobe_n <= 1'b1;
         data_port_out <= {DATA_W{1'b0}};
         data_port_oe <= 1'b0;
      end else if (clk_en) begin
         state <= next_state;
         rd_valid <= 1'b0;
         case (state)
            ST_PWR: begin
               if (pwr_done) begin
                  cnt <= {CNT_W{1'b0}};
                  powered <= 1'b1;
                  req_ready <= 1'b1;
               end else begin
                  cnt <= cnt + 1'b1;
               end
            end
            ST_IDLE: begin
               if (req_valid) begin
                  req_ready <= 1'b0;
                  is_write <= req_write;
                  word_address <= req_addr;
                  data_port_out <= req_wdata;
                  // Hold output enable high on writes so the port never contends
                  // enable high on writes
                  out_enable_n <= req_write;
                  data_port_oe <= req_write;
               end
            end
            ST_SETUP: begin
               select_low_active_n <= 1'b0;
               select_high_active <= 1'b1;
               cnt <= {CNT_W{1'b0}};
               if (is_write) begin
                  write_strobe_n <= 1'b0;
               end
            end
            ST_WR: begin
               if (wr_done) begin
                  write_strobe_n <= 1'b1;
               end else begin
                  cnt <= cnt + 1'b1;
               end
            end
            ST_WEND: begin
               // Data held one cycle past strobe rise for hold margin
               // deselect after strobe rise
               select_low_active_n <= 1'b1;
               select_high_active <= 1'b0;
               data_port_oe <= 1'b0;
               out_enable_n <= 1'b1;
               req_ready <= 1'b1;
            end
            ST_RD: begin
               if (rd_done) begin
                  rd_data <= data_port_in;
                  rd_valid <= 1'b1;
                  out_enable_n <= 1'b1;
               end else begin
                  cnt <= cnt + 1'b1;
               end
            end
            ST_REND: begin
               // Deselect a cycle after output enable to let the port float
               select_low_active_n <= 1'b1;
               select_high_active <= 1'b0;
               req_ready <= 1'b1;
            end
            default: begin
               cnt <= {CNT_W{1'b0}};
            end
         endcase
      end
   end

endmodule

`default_nettype wire

// File: asram_ctl_asserts.sv
// Pin checker for the static memory controller.
// Bound to asram_ctl; one clock, clk_en held high.
`timescale 1ns/1ps
`default_nettype none
module asram_ctl_asserts (
   // Clock and status
   input wire logic sys_clk, nrst, powered, rd_valid,
   // Memory pins
   input wire logic [20:0] word_address,
   input wire logic select_low_active_n, select_high_active, out_enable_n, write_strobe_n, data_port_oe
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   // ****
   // Pin rules
   // ****
   AST_IDLE: assert property (!powered |-> select_low_active_n) else $error("access before power-up");
   AST_SEL: assert property (select_low_active_n == !select_high_active) else $error("selects split");
   AST_WR: assert property (!write_strobe_n |-> !select_low_active_n && out_enable_n && data_port_oe)
      else $error("bad write pins");
   AST_RD: assert property (!out_enable_n && !select_low_active_n |-> write_strobe_n && !data_port_oe)
      else $error("bad read pins");
   AST_ADR: assert property ($fell(select_low_active_n) |-> $stable(word_address)) else $error("late address");
   AST_END: assert property ($rose(write_strobe_n) |-> data_port_oe && !select_low_active_n ##1
      select_low_active_n && !data_port_oe) else $error("data released early");
   AST_LEN: assert property ($fell(write_strobe_n) |-> ##1 write_strobe_n) else $error("strobe length");
   AST_RDV: assert property (rd_valid |-> !$past(out_enable_n) && !$past(select_low_active_n))
      else $error("read not enabled");
   C_WR: cover property ($fell(write_strobe_n));
   C_RD: cover property (rd_valid);
   C_PWR: cover property ($rose(powered));
endmodule
bind asram_ctl asram_ctl_asserts asram_ctl_asserts_inst (.sys_clk, .nrst, .powered, .rd_valid, .word_address,
   .select_low_active_n, .select_high_active, .out_enable_n, .write_strobe_n, .data_port_oe);
`default_nettype wire

// File: asram_mem.sv
// Behavioural 2M x 8 static memory on the controller pins.
// Forms the data wire level; released wire shows the inverse of its last value.
`timescale 1ns/1ps
`default_nettype none
module asram_mem (
   // Control
   input wire logic [20:0] word_address,
   input wire logic select_low_active_n, select_high_active, out_enable_n, write_strobe_n,
   // Data wire
   input wire logic [7:0] data_port_out,
   input wire logic data_port_oe,
   output logic [7:0] data_port_in
);
   logic [7:0] mem [int];
   logic [7:0] last = 8'h00;
   logic [7:0] rd;
   wire sel = !select_low_active_n && select_high_active;
   wire win = sel && !write_strobe_n;
   wire drv = sel && !out_enable_n && write_strobe_n;
   wire [7:0] dv = data_port_oe ? data_port_out : rd;
   always @* rd = mem.exists(word_address) ? mem[word_address] : 8'h00;
   always @(dv) if (data_port_oe || drv) last = dv;
   assign data_port_in = (data_port_oe || drv) ? dv : ~last;
   always @(negedge win) mem[word_address] = data_port_in;
endmodule
`default_nettype wire

// File: tb_asram_ctl.sv
// Testbench for asram_ctl with the memory model on its pins.
// Short power-up count; clk_en held high.
`timescale 1ns/1ps
`default_nettype none
module tb_asram_ctl;
   logic sys_clk = 0, nrst = 0, req_valid = 0, req_write = 0;
   logic [20:0] req_addr = 0, a;
   logic [7:0] req_wdata = 0, shadow [int], exp_q [$];
   wire req_ready, rd_valid, powered, select_low_active_n, select_high_active, out_enable_n, write_strobe_n;
   wire data_port_oe;
   wire [20:0] word_address;
   wire [7:0] rd_data, data_port_out, data_port_in;
   integer n_mismatch = 0, n_tests = 0, i, gap = 0;
   asram_ctl #(.POWERUP_CYC(4)) asram_ctl_inst (.sys_clk, .nrst, .clk_en(1'b1), .req_valid, .req_write,
      .req_addr, .req_wdata, .req_ready, .rd_valid, .rd_data, .powered, .word_address, .select_low_active_n,
      .select_high_active, .out_enable_n, .write_strobe_n, .data_port_in, .data_port_out, .data_port_oe);
   asram_mem asram_mem_inst (.word_address, .select_low_active_n, .select_high_active, .out_enable_n,
      .write_strobe_n, .data_port_out, .data_port_oe, .data_port_in);
   initial forever #12.5 sys_clk = ~sys_clk;
   task check(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task stop_test;
      $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // Request held until taken; bounded wait for ready
   task xfer(input logic w, input logic [20:0] ad);
      integer k;
      @(negedge sys_clk);
      req_valid = 1;
      req_write = w;
      req_addr = ad;
      req_wdata = $urandom;
      if (w) shadow[ad] = req_wdata;
      else exp_q.push_back(shadow[ad]);
      k = 0;
      do begin
         @(posedge sys_clk);
         k++;
      end while (req_ready !== 1'b1 && k < 40);
      if (k == 40) begin
         n_mismatch++;
         stop_test;
      end
   endtask
   always @(posedge sys_clk) if (rd_valid === 1'b1) check(rd_data, exp_q.pop_front());
   // Ready stays low for three sampled edges per write or read
   always @(posedge sys_clk) begin
      if (nrst !== 1'b1 || powered !== 1'b1) gap <= 0;
      else if (req_ready === 1'b0) gap <= gap + 1;
      else if (gap != 0) begin
         check(gap[7:0], 8'h03);
         gap <= 0;
      end
   end
   initial begin
      i = $urandom(32'h788ceb47);
      repeat (4) @(posedge sys_clk);
      @(negedge sys_clk) nrst = 1;
      check({7'h00, powered}, 8'h00);
      for (i = 0; i < 12; i++) begin
         a = (i < 2) ? {21{i[0]}} : $urandom;
         xfer(1, a);
         xfer(1, a);
         xfer(0, a);
         xfer(0, a);
      end
      check({7'h00, powered}, 8'h01);
      // Reset in write setup, before the strobe falls; the aborted address is never read back
      xfer(1, ~a);
      @(negedge sys_clk) nrst = 0;
      #1 check({7'h00, select_low_active_n, data_port_oe}, 8'h02);
      @(negedge sys_clk) nrst = 1;
      xfer(0, a);
      @(negedge sys_clk);
      req_valid = 0;
      repeat (6) @(posedge sys_clk);
      check(exp_q.size(), 8'h00);
      stop_test;
   end
endmodule
`default_nettype wire
